/* File: core/asp_uart.sv */
// Asynchronous 8N1 serial port with Avalon-MM register slave
`timescale 1ns/1ps
`include "asp_defines.svh"
module asp_uart import asp_pkg::*; (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [`ASP_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic rxd_i,
   output logic txd_o,
   output logic rx_irq_o,
   output logic tx_irq_o
);
   logic rst_meta_reg;
   logic rst_n;
   logic rxd_meta_reg;
   logic rxd_sync_reg;
   logic [15:0] div_reg;
   logic [7:0] ien_reg;
   logic [7:0] rx_hold_reg;
   logic rxf_reg;
   logic orun_reg;
   asp_tx_state_t tx_state_reg;
   logic [9:0] tx_shift_reg;
   logic [3:0] tx_cnt_reg;
   logic [7:0] tx_hold_reg;
   logic txf_reg;
   logic sample_tick;
   logic bit_tick;
   logic rx_done;
   logic [7:0] rx_data;
   logic req;
   logic done_edge;
   logic sel_status;
   logic sel_low;
   logic sel_high;
   logic sel_div;
   logic sel_ien;
   logic wr_evt;
   logic rd_evt;
   logic [7:0] wr_byte;
   logic tx_busy;
   logic tx_done;
   logic tx_start;
   logic [7:0] tx_src;
   logic [15:0] rd_word;

   function automatic logic hit(input logic [`ASP_ADDR_W-1:0] a,
                                input logic [15:0] idx);
      return a[`ASP_ADDR_W-1:2] == idx;
   endfunction

   // Reset release through two flops
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // Receive pin synchroniser
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rxd_meta_reg <= 1'b1;
         rxd_sync_reg <= 1'b1;
      end else begin
         rxd_meta_reg <= rxd_i;
         rxd_sync_reg <= rxd_meta_reg;
      end
   end

   asp_baud_gen u_baud (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n),
      .div_first_i(div_reg[15:8]),
      .div_second_i(div_reg[7:0]),
      .tx_run_i(tx_busy),
      .sample_tick_o(sample_tick),
      .bit_tick_o(bit_tick)
   );

   asp_rx u_rx (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n),
      .rx_i(rxd_sync_reg),
      .sample_tick_i(sample_tick),
      .div_second_i(div_reg[7:0]),
      .done_o(rx_done),
      .data_o(rx_data)
   );

   // Bus decode
   assign req = avs_read_i || avs_write_i;
   assign done_edge = req && !avs_waitrequest_o;
   assign sel_status = hit(avs_address_i, `ASP_IDX_STATUS);
   assign sel_low = hit(avs_address_i, `ASP_IDX_LOW);
   assign sel_high = hit(avs_address_i, `ASP_IDX_HIGH);
   assign sel_div = hit(avs_address_i, `ASP_IDX_DIV);
   assign sel_ien = hit(avs_address_i, `ASP_IDX_IEN);
   assign wr_evt = done_edge && avs_write_i &&
                   ((sel_low && avs_byteenable_i[0]) ||
                    (sel_high && avs_byteenable_i[1]));
   assign rd_evt = done_edge && avs_read_i && (sel_low || sel_high);
   assign wr_byte = sel_high ? avs_writedata_i[15:8] :
                    avs_writedata_i[7:0];

   // One wait cycle, then a single ready cycle
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest_o <= 1'b1;
      end else if (!avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b1;
      end else if (req) begin
         avs_waitrequest_o <= 1'b0;
      end
   end

   always_comb begin
      rd_word = 16'h0000;
      if (sel_status) begin
         rd_word[`ASP_ST_ORUN] = orun_reg;
         rd_word[`ASP_ST_RXF] = rxf_reg;
         rd_word[`ASP_ST_TXF] = txf_reg;
         rd_word[`ASP_ST_BUSY] = tx_busy;
      end else if (sel_low) begin
         rd_word = {8'h00, rx_hold_reg};
      end else if (sel_high) begin
         rd_word = {rx_hold_reg, 8'h00};
      end else if (sel_div) begin
         rd_word = div_reg;
      end else if (sel_ien) begin
         rd_word = {8'h00, ien_reg};
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (req && avs_waitrequest_o && avs_read_i) begin
         avs_readdata_o <= {16'h0000, rd_word};
      end
   end

   // Divider and interrupt enable registers
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= `ASP_DIV_RESET;
         ien_reg <= `ASP_IEN_RESET;
      end else if (done_edge && avs_write_i) begin
         if (sel_div && avs_byteenable_i[1])
            div_reg[15:8] <= avs_writedata_i[15:8];
         if (sel_div && avs_byteenable_i[0])
            div_reg[7:0] <= avs_writedata_i[7:0];
         if (sel_ien && avs_byteenable_i[0])
            ien_reg <= avs_writedata_i[7:0];
      end
   end

   // Receive holding register and flags
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rx_hold_reg <= 8'h00;
         rxf_reg <= 1'b0;
         orun_reg <= 1'b0;
      end else if (rx_done) begin
         rx_hold_reg <= rx_data;
         orun_reg <= rxf_reg;
         rxf_reg <= 1'b1;
      end else if (rd_evt) begin
         rxf_reg <= 1'b0;
      end
   end

   // Transmitter
   assign tx_busy = tx_state_reg == tx_shift;
   assign tx_done = tx_busy && bit_tick && tx_cnt_reg == `ASP_TX_LAST;
   assign tx_start = (!tx_busy && wr_evt) ||
                     (tx_done && (txf_reg || wr_evt));
   assign tx_src = txf_reg ? tx_hold_reg : wr_byte;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_reg <= tx_idle;
         tx_shift_reg <= 10'h3ff;
         tx_cnt_reg <= 4'h0;
      end else if (tx_start) begin
         tx_shift_reg <= {1'b1, tx_src, 1'b0};
         tx_cnt_reg <= 4'h0;
         tx_state_reg <= tx_shift;
      end else if (tx_done) begin
         tx_state_reg <= tx_idle;
      end else if (tx_busy && bit_tick) begin
         tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
         tx_cnt_reg <= tx_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         txf_reg <= 1'b0;
         tx_hold_reg <= 8'h00;
      end else if (wr_evt && tx_busy && !tx_done) begin
         txf_reg <= 1'b1;
         tx_hold_reg <= wr_byte;
      end else if (tx_done && txf_reg) begin
         txf_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         txd_o <= 1'b1;
      end else begin
         txd_o <= tx_busy ? tx_shift_reg[0] : 1'b1;
      end
   end

   // Interrupt request pulses
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rx_irq_o <= 1'b0;
         tx_irq_o <= 1'b0;
      end else begin
         rx_irq_o <= rx_done && ien_reg[`ASP_IEN_RX];
         tx_irq_o <= tx_start && ien_reg[`ASP_IEN_TX];
      end
   end

   // Clocks between transmit bit ticks, for the bit-time check
   logic [15:0] bit_gap_reg;
   logic [15:0] bit_len;
   logic gap_armed_reg;

   assign bit_len = ({8'h00, div_reg[15:8]} + 16'h0001) *
                    {8'h00, div_reg[7:0]};

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         bit_gap_reg <= 16'h0000;
         gap_armed_reg <= 1'b0;
      end else if (bit_tick) begin
         bit_gap_reg <= 16'h0001;
         gap_armed_reg <= tx_start || !tx_done;
      end else begin
         bit_gap_reg <= bit_gap_reg + 16'h0001;
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n);

   a_wait_answer: assert property (
      req && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("waitrequest did not drop");
   a_wait_single: assert property (
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   a_idle_line_high: assert property (
      !tx_busy && !$past(tx_busy) |=> txd_o)
      else $error("line not idle high");
   a_start_bit_low: assert property (
      tx_start |-> ##2 !txd_o)
      else $error("no start bit");
   a_stop_bit_high: assert property (
      tx_done |-> txd_o)
      else $error("stop bit not high");
   a_overrun_copy: assert property (
      rx_done |=> orun_reg == $past(rxf_reg))
      else $error("overrun not copied");
   a_rx_store: assert property (
      rx_done |=> rxf_reg && rx_hold_reg == $past(rx_data))
      else $error("byte not stored");
   a_read_clears: assert property (
      rd_evt && !rx_done |=> !rxf_reg)
      else $error("read did not clear full");
   a_low_read_upper: assert property (
      done_edge && avs_read_i && sel_low |-> avs_readdata_o[31:8] == 24'h0)
      else $error("upper bits not zero");
   a_rx_irq_gate: assert property (
      rx_irq_o |-> $past(rx_done) && $past(ien_reg[`ASP_IEN_RX]))
      else $error("receive request not gated");
   a_tx_irq_gate: assert property (
      tx_irq_o |-> $past(tx_start) && $past(ien_reg[`ASP_IEN_TX]))
      else $error("transmit request not gated");
   a_irq_pulse: assert property (
      rx_irq_o |=> !rx_irq_o)
      else $error("request longer than a pulse");
   a_idle_write: assert property (
      wr_evt && !tx_busy |=> tx_busy && !txf_reg)
      else $error("idle write not started");
   a_busy_write: assert property (
      wr_evt && tx_busy && !tx_done |=> txf_reg)
      else $error("busy write not held");

   // Bit timing, byte lanes, status and pulse shapes
   a_tx_irq_pulse: assert property (
      tx_irq_o |=> !tx_irq_o)
      else $error("transmit request longer than a pulse");
   a_rx_irq_fires: assert property (
      rx_done && ien_reg[`ASP_IEN_RX] |=> rx_irq_o)
      else $error("receive request missing");
   a_tx_irq_fires: assert property (
      tx_start && ien_reg[`ASP_IEN_TX] |=> tx_irq_o)
      else $error("transmit request missing");
   a_busy_report: assert property (
      done_edge && avs_read_i && sel_status |->
      avs_readdata_o[`ASP_ST_BUSY] == $past(tx_busy))
      else $error("busy flag misreported");
   a_status_upper: assert property (
      done_edge && avs_read_i && sel_status |->
      avs_readdata_o[31:4] == 28'h0000000)
      else $error("status upper bits not zero");
   a_high_read_lower: assert property (
      done_edge && avs_read_i && sel_high |->
      avs_readdata_o[7:0] == 8'h00 && avs_readdata_o[31:16] == 16'h0000)
      else $error("high read lanes not zero");
   a_unmapped_read: assert property (
      done_edge && avs_read_i &&
      !(sel_status || sel_low || sel_high || sel_div || sel_ien) |->
      avs_readdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_low_byte_sent: assert property (
      wr_evt && sel_low && !tx_busy |=>
      tx_shift_reg[8:1] == $past(avs_writedata_i[7:0]))
      else $error("low byte not loaded");
   a_high_byte_sent: assert property (
      wr_evt && sel_high && !tx_busy |=>
      tx_shift_reg[8:1] == $past(avs_writedata_i[15:8]))
      else $error("high byte not loaded");
   a_held_byte_sent: assert property (
      tx_done && txf_reg |=>
      !txf_reg && tx_busy && tx_shift_reg[8:1] == $past(tx_hold_reg))
      else $error("held byte not loaded");
   a_div_write: assert property (
      done_edge && avs_write_i && sel_div && avs_byteenable_i[1:0] == 2'b11
      |=> div_reg == $past(avs_writedata_i[15:0]))
      else $error("divider not written");
   a_bit_time: assert property (
      bit_tick && gap_armed_reg |-> bit_gap_reg == bit_len)
      else $error("bit time wrong");

   c_rx_byte: cover property (rx_done);
   c_overrun: cover property (rx_done && rxf_reg);
   c_back_to_back: cover property (tx_done && txf_reg);
   c_held_write: cover property (wr_evt && tx_busy);
   c_masked_rx: cover property (rx_done && !ien_reg[`ASP_IEN_RX]);
endmodule

/* File: core/asp_defines.svh */
// Constants for the asynchronous 8N1 serial port
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH
`define ASP_ADDR_W 18
`define ASP_IDX_STATUS 16'hc028
`define ASP_IDX_LOW 16'hc029
`define ASP_IDX_HIGH 16'hc02a
`define ASP_IDX_DIV 16'hc02b
`define ASP_IDX_IEN 16'hc01a
`define ASP_ST_ORUN 3
`define ASP_ST_RXF 2
`define ASP_ST_TXF 1
`define ASP_ST_BUSY 0
`define ASP_IEN_RX 5
`define ASP_IEN_TX 4
`define ASP_DIV_RESET 16'h0000
`define ASP_IEN_RESET 8'h00
`define ASP_TX_LAST 4'h9
`define ASP_RX_LAST 3'h7
`endif

/* File: core/asp_pkg.sv */
// Types for the asynchronous 8N1 serial port
package asp_pkg;
   typedef enum logic [3:0] {
      rx_idle = 4'b0001,
      rx_start = 4'b0010,
      rx_data = 4'b0100,
      rx_stop = 4'b1000
   } asp_rx_state_t;
   typedef enum logic [1:0] {
      tx_idle = 2'b01,
      tx_shift = 2'b10
   } asp_tx_state_t;
endpackage

/* File: core/asp_baud_gen.sv */
// Two-stage baud divider
`timescale 1ns/1ps
`include "asp_defines.svh"
module asp_baud_gen (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] div_first_i,
   input wire logic [7:0] div_second_i,
   input wire logic tx_run_i,
   output logic sample_tick_o,
   output logic bit_tick_o
);
   logic [7:0] first_cnt_reg;
   logic [7:0] second_cnt_reg;

   // Stage one: one tick every first divider plus one clocks
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         first_cnt_reg <= 8'h00;
         sample_tick_o <= 1'b0;
      end else if (first_cnt_reg == div_first_i) begin
         first_cnt_reg <= 8'h00;
         sample_tick_o <= 1'b1;
      end else begin
         first_cnt_reg <= first_cnt_reg + 8'h01;
         sample_tick_o <= 1'b0;
      end
   end

   // Stage two: transmit bit tick, restarted with each frame
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         second_cnt_reg <= 8'h00;
         bit_tick_o <= 1'b0;
      end else if (!tx_run_i) begin
         second_cnt_reg <= 8'h00;
         bit_tick_o <= 1'b0;
      end else if (sample_tick_o &&
                   second_cnt_reg == div_second_i - 8'h01) begin
         second_cnt_reg <= 8'h00;
         bit_tick_o <= 1'b1;
      end else begin
         if (sample_tick_o)
            second_cnt_reg <= second_cnt_reg + 8'h01;
         bit_tick_o <= 1'b0;
      end
   end
endmodule

/* File: core/asp_rx.sv */
// Serial receiver: start detect, mid-bit sampling, stop check
`timescale 1ns/1ps
`include "asp_defines.svh"
module asp_rx import asp_pkg::*; (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic rx_i,
   input wire logic sample_tick_i,
   input wire logic [7:0] div_second_i,
   output logic done_o,
   output logic [7:0] data_o
);
   asp_rx_state_t state_reg;
   logic prev_reg;
   logic [7:0] tick_cnt_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic bit_end;

   assign bit_end = sample_tick_i && tick_cnt_reg == div_second_i - 8'h01;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_reg <= 1'b1;
      end else begin
         prev_reg <= rx_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= rx_idle;
         tick_cnt_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         done_o <= 1'b0;
         data_o <= 8'h00;
      end else begin
         done_o <= 1'b0;
         case (state_reg)
            rx_idle: begin
               tick_cnt_reg <= 8'h00;
               if (prev_reg && !rx_i)
                  state_reg <= rx_start;
            end
            rx_start: begin
               if (sample_tick_i) begin
                  if (tick_cnt_reg ==
                      {1'b0, div_second_i[7:1]} - 8'h01) begin
                     tick_cnt_reg <= 8'h00;
                     bit_cnt_reg <= 3'h0;
                     state_reg <= rx_i ? rx_idle : rx_data;
                  end else begin
                     tick_cnt_reg <= tick_cnt_reg + 8'h01;
                  end
               end
            end
            rx_data: begin
               if (bit_end) begin
                  tick_cnt_reg <= 8'h00;
                  shift_reg <= {rx_i, shift_reg[7:1]};
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == `ASP_RX_LAST)
                     state_reg <= rx_stop;
               end else if (sample_tick_i) begin
                  tick_cnt_reg <= tick_cnt_reg + 8'h01;
               end
            end
            rx_stop: begin
               if (bit_end) begin
                  tick_cnt_reg <= 8'h00;
                  state_reg <= rx_idle;
                  if (rx_i) begin
                     done_o <= 1'b1;
                     data_o <= shift_reg;
                  end
               end else if (sample_tick_i) begin
                  tick_cnt_reg <= tick_cnt_reg + 8'h01;
               end
            end
            default: state_reg <= rx_idle;
         endcase
      end
   end
endmodule

/* File: verif/asp_term_model.sv */
// Serial terminal model: drives frames on rxd, decodes frames from txd
`timescale 1ns/1ps
module asp_term_model #(
   parameter int BIT_CLKS = 12
) (
   input wire logic mclk_i,
   input wire logic txd_i,
   output logic rxd_o
);
   logic [8:0] got_q[$];
   logic [8:0] got;

   initial begin
      rxd_o = 1'b1;
   end

   // Low stop_hi forces a framing fault
   task automatic send(input logic [7:0] b, input logic stop_hi);
      logic [9:0] frame;
      frame = {stop_hi, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd_o <= frame[i];
         repeat (BIT_CLKS) @(posedge mclk_i);
      end
      rxd_o <= 1'b1;
   endtask

   // Mid-bit sampling of each transmitted frame, stop kept in bit 8
   always begin
      @(negedge txd_i);
      repeat (BIT_CLKS / 2) @(posedge mclk_i);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT_CLKS) @(posedge mclk_i);
         got[i] = txd_i;
      end
      got_q.push_back(got);
   end
endmodule

/* File: verif/async_serial_port_8n1_bench.sv */
// Self-checking bench for the 8N1 serial port
`timescale 1ns/1ps
`include "asp_defines.svh"
module async_serial_port_8n1_bench;
   localparam int BIT_CLKS = 12;
   logic mclk_i;
   logic rst_n_i;
   logic [`ASP_ADDR_W-1:0] avs_address_i;
   logic avs_read_i;
   logic avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0] avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic rxd_i;
   logic txd_o;
   logic rx_irq_o;
   logic tx_irq_o;
   logic [31:0] rd;
   int bad_count;
   int num_checks;
   int cycles;
   int rx_irqs;
   int tx_irqs;

   asp_uart dut_u (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .rxd_i(rxd_i),
      .txd_o(txd_o),
      .rx_irq_o(rx_irq_o),
      .tx_irq_o(tx_irq_o)
   );

   asp_term_model #(.BIT_CLKS(BIT_CLKS)) term_u (
      .mclk_i(mclk_i),
      .txd_i(txd_o),
      .rxd_o(rxd_i)
   );

   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) begin
      cycles++;
      if (rx_irq_o === 1'b1) rx_irqs++;
      if (tx_irq_o === 1'b1) tx_irqs++;
      if (cycles == 20000) begin
         bad_count++;
         $display("timeout");
         final_report();
      end
   end

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic w, input logic [15:0] idx,
                      input logic [31:0] wd, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge mclk_i);
      avs_address_i <= {idx, 2'b00};
      avs_writedata_i <= wd;
      avs_byteenable_i <= be;
      avs_write_i <= w;
      avs_read_i <= ~w;
      do begin
         @(posedge mclk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      check("wait cycles", 32'(n), 32'h2);
   endtask

   task automatic rd_chk(string what, logic [15:0] idx, logic [31:0] exp);
      bus(1'b0, idx, 32'h0, 4'hf);
      check(what, rd, exp);
   endtask

   task automatic wait_tx(int n);
      while (term_u.got_q.size() < n) begin
         @(posedge mclk_i);
      end
   endtask

   task automatic rx_frame(logic [7:0] b, logic stop_hi);
      term_u.send(b, stop_hi);
      repeat (4) @(posedge mclk_i);
   endtask

   task automatic test_reset();
      rd_chk("status", `ASP_IDX_STATUS, 32'h0);
      rd_chk("divider", `ASP_IDX_DIV, 32'h0);
      rd_chk("unmapped", 16'hc027, 32'h0);
      bus(1'b1, `ASP_IDX_DIV, 32'hffff_0106, 4'h3);
      rd_chk("divider", `ASP_IDX_DIV, 32'h0000_0106);
      bus(1'b1, `ASP_IDX_IEN, 32'h30, 4'h1);
      rd_chk("enable", `ASP_IDX_IEN, 32'h30);
      $display("test reset done");
   endtask

   task automatic test_tx();
      bus(1'b1, `ASP_IDX_LOW, 32'h1234_a53c, 4'h3);
      repeat (3) @(posedge mclk_i);
      check("tx irqs", 32'(tx_irqs), 32'h1);
      rd_chk("status", `ASP_IDX_STATUS, 32'h1);
      bus(1'b1, `ASP_IDX_HIGH, 32'h5a5a_96ff, 4'h3);
      rd_chk("status", `ASP_IDX_STATUS, 32'h3);
      check("tx irqs", 32'(tx_irqs), 32'h1);
      wait_tx(1);
      check("frame", 32'(term_u.got_q.pop_front()), 32'h13c);
      repeat (BIT_CLKS) @(posedge mclk_i);
      check("tx irqs", 32'(tx_irqs), 32'h2);
      wait_tx(1);
      check("frame", 32'(term_u.got_q.pop_front()), 32'h196);
      repeat (BIT_CLKS + 4) @(posedge mclk_i);
      rd_chk("status", `ASP_IDX_STATUS, 32'h0);
      $display("test tx done");
   endtask

   task automatic test_rx();
      rx_frame(8'h5a, 1'b1);
      check("rx irqs", 32'(rx_irqs), 32'h1);
      rd_chk("status", `ASP_IDX_STATUS, 32'h4);
      rd_chk("low data", `ASP_IDX_LOW, 32'h005a);
      rd_chk("status", `ASP_IDX_STATUS, 32'h0);
      rx_frame(8'hc3, 1'b1);
      rx_frame(8'h81, 1'b1);
      rd_chk("status", `ASP_IDX_STATUS, 32'hc);
      rd_chk("high data", `ASP_IDX_HIGH, 32'h8100);
      rx_frame(8'h24, 1'b1);
      rd_chk("status", `ASP_IDX_STATUS, 32'h4);
      rd_chk("low data", `ASP_IDX_LOW, 32'h0024);
      rx_frame(8'he7, 1'b0);
      check("rx irqs", 32'(rx_irqs), 32'h4);
      rd_chk("status", `ASP_IDX_STATUS, 32'h0);
      $display("test rx done");
   endtask

   task automatic test_mask();
      bus(1'b1, `ASP_IDX_IEN, 32'h0, 4'h1);
      rx_frame(8'h11, 1'b1);
      check("rx irqs", 32'(rx_irqs), 32'h4);
      rd_chk("low data", `ASP_IDX_LOW, 32'h0011);
      bus(1'b1, `ASP_IDX_LOW, 32'h0000_0022, 4'h1);
      wait_tx(1);
      check("tx irqs", 32'(tx_irqs), 32'h2);
      check("frame", 32'(term_u.got_q.pop_front()), 32'h122);
      $display("test mask done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      rst_n_i = 1'b0;
      avs_address_i = '0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'h0;
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      test_reset();
      test_tx();
      test_rx();
      test_mask();
      final_report();
   end
endmodule
